// ### verilog/pbi_dev_end.sv
// Capture device end of the PCI pins: configuration target plus a
// single-word bus master driven from a local request port.
// Assumes the host end drives select, grant and bus reset and only
// issues configuration cycles toward this end.
`timescale 1ns/10ps
`default_nettype none
module pbi_dev_end
  import pbi_pkg::*;
#(
  parameter logic [AD_W-1:0] DEV_ID = 32'h00c0_ffee // Arbitrary value
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  pbi_bus_if.dev_mp bus,
  input wire logic mst_req_i,
  input wire logic [3:0] mst_cmd_i,
  input wire logic [AD_W-1:0] mst_addr_i,
  input wire logic [BE_W-1:0] mst_be_i,
  input wire logic [AD_W-1:0] mst_wdata_i,
  output logic mst_busy_o,
  output logic mst_done_o,
  output logic mst_abort_o,
  output logic [AD_W-1:0] mst_rdata_o,
  output logic [AD_W-1:0] cfg_ctrl_o
);

  typedef struct packed {
    pbi_tst_type tst;
    pbi_mst_type mst;
    logic frame_q;
    logic t_write;
    logic [CFG_IDX_W-1:0] t_idx;
    logic [2**CFG_IDX_W-1:0][AD_W-1:0] cfg;
    logic [AD_W-1:0] ad_out;
    logic ad_oe;
    logic [BE_W-1:0] cbe_out;
    logic m_oe;
    logic frame_a;
    logic irdy_a;
    logic trdy_a;
    logic devsel_a;
    logic t_oe;
    logic m_write;
    logic [2:0] m_cnt;
    logic [AD_W-1:0] m_addr;
    logic [3:0] m_cmd;
    logic [BE_W-1:0] m_be_n;
    logic [AD_W-1:0] m_wdata;
    logic [AD_W-1:0] rdata;
    logic done;
    logic abort;
  } pbi_dev_type;

  pbi_dev_type s_reg;
  pbi_dev_type s_next;
  logic frame_now;
  logic addr_ph;
  logic is_cfg;
  logic bus_idle;
  logic [AD_W-1:0] rd_word;
  logic [CFG_IDX_W-1:0] nxt_idx;

  // Pins as seen at this edge; start of frame marks the address phase
  assign frame_now = !bus.frame_n;
  assign addr_ph = frame_now && !s_reg.frame_q;
  assign is_cfg = (bus.cbe_n == CMD_CFG_RD) || (bus.cbe_n == CMD_CFG_WR);
  assign bus_idle = bus.frame_n && bus.irdy_n;
  assign nxt_idx = s_reg.t_idx + 1'b1;
  // Word zero is the fixed identity, never written
  assign rd_word = (nxt_idx == CFG_ID_IDX) ? DEV_ID : s_reg.cfg[nxt_idx];

  always_comb begin
    s_next = s_reg;
    s_next.frame_q = frame_now;
    s_next.done = 1'b0;
    s_next.abort = 1'b0;

    // Target side: configuration space only
    unique case (s_reg.tst)
      T_IDLE: begin
        // Type 0 dword address, and only with select high
        if (addr_ph && bus.idsel && is_cfg &&
            bus.ad[IDX_LSB-1:0] == ADDR_TYPE0) begin
          s_next.tst = T_DEC;
          s_next.t_write = bus.cbe_n[CMD_WR_BIT];
          s_next.t_idx = bus.ad[IDX_LSB +: CFG_IDX_W];
          s_next.devsel_a = 1'b1;
          s_next.trdy_a = 1'b0;
          s_next.t_oe = 1'b1;
        end
      end
      T_DEC: begin
        // Turnaround cycle before driving read data
        s_next.tst = T_DATA;
        s_next.trdy_a = 1'b1;
        if (!s_reg.t_write) begin
          s_next.ad_out = (s_reg.t_idx == CFG_ID_IDX) ? DEV_ID :
                          s_reg.cfg[s_reg.t_idx];
          s_next.ad_oe = 1'b1;
        end
      end
      T_DATA: begin
        if (!bus.irdy_n) begin
          // Data phase ends when both ready signals are low
          if (s_reg.t_write && s_reg.t_idx != CFG_ID_IDX) begin
            s_next.cfg[s_reg.t_idx] = pbi_merge(s_reg.cfg[s_reg.t_idx],
              bus.ad, bus.cbe_n);
          end
          s_next.t_idx = nxt_idx;
          if (bus.frame_n) begin
            // Final phase: drive deasserted one cycle, then float
            s_next.tst = T_TURN;
            s_next.trdy_a = 1'b0;
            s_next.devsel_a = 1'b0;
            s_next.ad_oe = 1'b0;
          end else if (!s_reg.t_write) begin
            s_next.ad_out = rd_word;
          end
        end
      end
      T_TURN: begin
        s_next.t_oe = 1'b0;
        s_next.tst = T_IDLE;
      end
      default: begin
        s_next.tst = T_IDLE;
      end
    endcase

    // Master side: one data phase per request
    unique case (s_reg.mst)
      M_IDLE: begin
        if (mst_req_i) begin
          s_next.mst = M_REQ;
          s_next.m_cmd = mst_cmd_i;
          s_next.m_addr = mst_addr_i;
          s_next.m_be_n = ~mst_be_i;
          s_next.m_wdata = mst_wdata_i;
          s_next.m_write = mst_cmd_i[CMD_WR_BIT];
        end
      end
      M_REQ: begin
        // Grant sampled low with the bus idle before starting
        if (!bus.gnt_n && bus_idle && s_reg.tst == T_IDLE) begin
          s_next.mst = M_ADDR;
          s_next.frame_a = 1'b1;
          s_next.m_oe = 1'b1;
          s_next.ad_out = s_reg.m_addr;
          s_next.ad_oe = 1'b1;
          s_next.cbe_out = s_reg.m_cmd;
        end
      end
      M_ADDR: begin
        // Single phase, so frame drops as ready rises
        s_next.mst = M_DATA;
        s_next.frame_a = 1'b0;
        s_next.irdy_a = 1'b1;
        s_next.cbe_out = s_reg.m_be_n;
        s_next.m_cnt = '0;
        if (s_reg.m_write) begin
          s_next.ad_out = s_reg.m_wdata;
        end else begin
          s_next.ad_oe = 1'b0;
        end
      end
      M_DATA: begin
        s_next.m_cnt = s_reg.m_cnt + 1'b1;
        if (!bus.trdy_n && !bus.devsel_n) begin
          s_next.rdata = s_reg.m_write ? s_reg.rdata : bus.ad;
          s_next.done = 1'b1;
          s_next.mst = M_TURN;
          s_next.irdy_a = 1'b0;
          s_next.ad_oe = 1'b0;
        end else if (bus.devsel_n && s_reg.m_cnt == ABORT_CYC) begin
          // Nobody claimed it: give up rather than hang the bus
          s_next.abort = 1'b1;
          s_next.mst = M_TURN;
          s_next.irdy_a = 1'b0;
          s_next.ad_oe = 1'b0;
        end
      end
      M_TURN: begin
        s_next.m_oe = 1'b0;
        s_next.mst = M_IDLE;
      end
      default: begin
        s_next.mst = M_IDLE;
      end
    endcase
  end

  // Either reset clears state; all pins float
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || !bus.rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Enables gated by bus reset so pins float without a clock edge
  assign bus.d_frame_n = !s_reg.frame_a;
  assign bus.d_irdy_n = !s_reg.irdy_a;
  assign bus.d_frame_oe = s_reg.m_oe && bus.rst_n;
  assign bus.d_irdy_oe = s_reg.m_oe && bus.rst_n;
  assign bus.d_cbe_oe = s_reg.m_oe && bus.rst_n;
  assign bus.d_cbe_n = s_reg.cbe_out;
  assign bus.d_trdy_n = !s_reg.trdy_a;
  assign bus.d_devsel_n = !s_reg.devsel_a;
  assign bus.d_tgt_oe = s_reg.t_oe && bus.rst_n;
  assign bus.d_ad = s_reg.ad_out;
  assign bus.d_ad_oe = s_reg.ad_oe && bus.rst_n;

  // Local side
  assign mst_busy_o = (s_reg.mst != M_IDLE);
  assign mst_done_o = s_reg.done;
  assign mst_abort_o = s_reg.abort;
  assign mst_rdata_o = s_reg.rdata;
  assign cfg_ctrl_o = s_reg.cfg[CFG_CTRL_IDX];

endmodule : pbi_dev_end
`default_nettype wire

// ### verilog/pbi_pkg.sv
// Constants, types and helpers shared by both ends of the PCI pin link.
// Assumes both ends run on one PCI clock and import this package whole.
// Notes on behaviour
// - All bus pins sampled on rising clock edge
// - Bus reset floats every output at once
// - Configuration claimed only while select input high
// - One address phase, then data phases
// - Address phase: first cycle frame seen asserted
// - I/O byte address, memory/config dword address
// - Low lane least, top lane most significant
// - Read data valid whenever target ready asserted
// - Command in address phase, byte enables later
// - Byte enables valid through data phase
// - Top enable top lane, bottom enable bottom
package pbi_pkg;

  localparam int AD_W = 32;
  localparam int BE_W = 4;
  localparam int BYTE_W = 8;
  localparam int CFG_IDX_W = 2;
  localparam int MEM_IDX_W = 3;
  localparam int IDX_LSB = 2;

  // Bus commands carried on the command lines in the address phase
  localparam logic [3:0] CMD_IO_RD = 4'h2;
  localparam logic [3:0] CMD_IO_WR = 4'h3;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_CFG_RD = 4'ha;
  localparam logic [3:0] CMD_CFG_WR = 4'hb;
  localparam int CMD_WR_BIT = 0;

  localparam logic [1:0] ADDR_TYPE0 = 2'h0;
  localparam logic [CFG_IDX_W-1:0] CFG_ID_IDX = 2'h0;
  localparam logic [CFG_IDX_W-1:0] CFG_CTRL_IDX = 2'h1;
  localparam logic [2:0] ABORT_CYC = 3'h5;
  localparam logic [AD_W-1:0] AD_PULL = 32'hffff_ffff;
  localparam logic [BE_W-1:0] BE_PULL = 4'hf;

  typedef enum logic [1:0] {T_IDLE, T_DEC, T_DATA, T_TURN} pbi_tst_type;
  typedef enum logic [2:0] {M_IDLE, M_REQ, M_ADDR, M_DATA, M_TURN}
    pbi_mst_type;

  // Lane n of the word follows enable n, lane 0 lowest
  function automatic logic [AD_W-1:0] pbi_merge(
    input logic [AD_W-1:0] old_w,
    input logic [AD_W-1:0] new_w,
    input logic [BE_W-1:0] be_n);
    logic [AD_W-1:0] res;
    res = old_w;
    for (int i = 0; i < BE_W; i++) begin
      if (!be_n[i]) begin
        res[i*BYTE_W +: BYTE_W] = new_w[i*BYTE_W +: BYTE_W];
      end
    end
    return res;
  endfunction : pbi_merge

endpackage : pbi_pkg

// ### verilog/pbi_bus_if.sv
// Shared PCI wires between the capture device end and the host end.
// Assumes each end drives its pins only with its enable high; an idle
// wire reads as pulled high, as the bus pull-ups would make it.
`timescale 1ns/10ps
`default_nettype none
interface pbi_bus_if;
  import pbi_pkg::*;

  // Device end drivers
  logic d_frame_n, d_frame_oe, d_irdy_n, d_irdy_oe;
  logic d_trdy_n, d_devsel_n, d_tgt_oe;
  logic [AD_W-1:0] d_ad;
  logic d_ad_oe;
  logic [BE_W-1:0] d_cbe_n;
  logic d_cbe_oe;
  // Host end drivers
  logic h_frame_n, h_frame_oe, h_irdy_n, h_irdy_oe;
  logic h_trdy_n, h_devsel_n, h_tgt_oe;
  logic [AD_W-1:0] h_ad;
  logic h_ad_oe;
  logic [BE_W-1:0] h_cbe_n;
  logic h_cbe_oe;
  // Host-only pins
  logic idsel, gnt_n, rst_n;
  // Resolved wire levels
  logic frame_n, irdy_n, trdy_n, devsel_n;
  logic [AD_W-1:0] ad;
  logic [BE_W-1:0] cbe_n;

  // Whichever end enables wins, the device end if both do; nobody driving reads high
  assign frame_n = d_frame_oe ? d_frame_n : h_frame_oe ? h_frame_n : 1'b1;
  assign irdy_n = d_irdy_oe ? d_irdy_n : h_irdy_oe ? h_irdy_n : 1'b1;
  assign trdy_n = d_tgt_oe ? d_trdy_n : h_tgt_oe ? h_trdy_n : 1'b1;
  assign devsel_n = d_tgt_oe ? d_devsel_n : h_tgt_oe ? h_devsel_n : 1'b1;
  assign ad = d_ad_oe ? d_ad : h_ad_oe ? h_ad : AD_PULL;
  assign cbe_n = d_cbe_oe ? d_cbe_n : h_cbe_oe ? h_cbe_n : BE_PULL;

  modport dev_mp (
    input frame_n, irdy_n, trdy_n, devsel_n, ad, cbe_n, idsel, gnt_n,
    rst_n,
    output d_frame_n, d_frame_oe, d_irdy_n, d_irdy_oe, d_trdy_n,
    d_devsel_n, d_tgt_oe, d_ad, d_ad_oe, d_cbe_n, d_cbe_oe);
  modport hst_mp (
    input frame_n, irdy_n, trdy_n, devsel_n, ad, cbe_n,
    output h_frame_n, h_frame_oe, h_irdy_n, h_irdy_oe, h_trdy_n,
    h_devsel_n, h_tgt_oe, h_ad, h_ad_oe, h_cbe_n, h_cbe_oe, idsel, gnt_n,
    rst_n);
endinterface : pbi_bus_if
`default_nettype wire

// ### verilog/pbi_hst_end.sv
// Host end of the PCI pins: arbiter, bus reset, memory target for the
// device's transfers and a single-word master with select drive.
// Assumes one device on the bus, served by an eight-word memory here.
`timescale 1ns/10ps
`default_nettype none
module pbi_hst_end
  import pbi_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  pbi_bus_if.hst_mp bus,
  input wire logic hst_req_i,
  input wire logic [3:0] hst_cmd_i,
  input wire logic [AD_W-1:0] hst_addr_i,
  input wire logic [BE_W-1:0] hst_be_i,
  input wire logic [AD_W-1:0] hst_wdata_i,
  output logic hst_busy_o,
  output logic hst_done_o,
  output logic hst_abort_o,
  output logic [AD_W-1:0] hst_rdata_o
);

  typedef struct packed {
    pbi_tst_type tst;
    pbi_mst_type mst;
    logic rst_done;
    logic gnt_a;
    logic idsel_a;
    logic frame_q;
    logic t_write;
    logic [MEM_IDX_W-1:0] t_idx;
    logic [2**MEM_IDX_W-1:0][AD_W-1:0] mem;
    logic [AD_W-1:0] ad_out;
    logic ad_oe;
    logic [BE_W-1:0] cbe_out;
    logic m_oe;
    logic frame_a;
    logic irdy_a;
    logic trdy_a;
    logic devsel_a;
    logic t_oe;
    logic [2:0] m_cnt;
    logic [AD_W-1:0] rdata;
    logic done;
    logic abort;
  } pbi_hst_type;

  pbi_hst_type s_reg;
  pbi_hst_type s_next;
  logic frame_now;
  logic addr_ph;
  logic is_mem;
  logic is_cfg;
  logic [MEM_IDX_W-1:0] nxt_idx;

  assign frame_now = !bus.frame_n;
  assign addr_ph = frame_now && !s_reg.frame_q;
  assign is_mem = (bus.cbe_n == CMD_MEM_RD) || (bus.cbe_n == CMD_MEM_WR);
  assign is_cfg = (hst_cmd_i == CMD_CFG_RD) || (hst_cmd_i == CMD_CFG_WR);
  assign nxt_idx = s_reg.t_idx + 1'b1;

  always_comb begin
    s_next = s_reg;
    s_next.rst_done = 1'b1;
    s_next.frame_q = frame_now;
    s_next.done = 1'b0;
    s_next.abort = 1'b0;
    // Grant parked on the device while this master is idle
    s_next.gnt_a = (s_reg.mst == M_IDLE) && !hst_req_i;

    // Target side: memory commands, dword index, burst capable
    unique case (s_reg.tst)
      T_IDLE: begin
        if (addr_ph && is_mem) begin
          s_next.tst = T_DEC;
          s_next.t_write = bus.cbe_n[CMD_WR_BIT];
          s_next.t_idx = bus.ad[IDX_LSB +: MEM_IDX_W];
          s_next.devsel_a = 1'b1;
          s_next.t_oe = 1'b1;
        end
      end
      T_DEC: begin
        s_next.tst = T_DATA;
        s_next.trdy_a = 1'b1;
        s_next.ad_out = s_reg.mem[s_reg.t_idx];
        s_next.ad_oe = !s_reg.t_write;
      end
      T_DATA: begin
        if (!bus.irdy_n) begin
          if (s_reg.t_write) begin
            s_next.mem[s_reg.t_idx] = pbi_merge(s_reg.mem[s_reg.t_idx],
              bus.ad, bus.cbe_n);
          end
          s_next.t_idx = nxt_idx;
          s_next.ad_out = s_reg.mem[nxt_idx];
          if (bus.frame_n) begin
            s_next.tst = T_TURN;
            s_next.trdy_a = 1'b0;
            s_next.devsel_a = 1'b0;
            s_next.ad_oe = 1'b0;
          end
        end
      end
      T_TURN: begin
        s_next.t_oe = 1'b0;
        s_next.tst = T_IDLE;
      end
      default: begin
        s_next.tst = T_IDLE;
      end
    endcase

    // Master side: waits one cycle with grant withdrawn
    unique case (s_reg.mst)
      M_IDLE: begin
        if (hst_req_i) begin
          s_next.mst = M_REQ;
        end
      end
      M_REQ: begin
        if (!s_reg.gnt_a && bus.frame_n && bus.irdy_n &&
            s_reg.tst == T_IDLE) begin
          s_next.mst = M_ADDR;
          s_next.frame_a = 1'b1;
          s_next.m_oe = 1'b1;
          s_next.ad_out = hst_addr_i;
          s_next.ad_oe = 1'b1;
          s_next.cbe_out = hst_cmd_i;
          s_next.idsel_a = is_cfg;
        end
      end
      M_ADDR: begin
        s_next.mst = M_DATA;
        s_next.frame_a = 1'b0;
        s_next.irdy_a = 1'b1;
        s_next.idsel_a = 1'b0;
        s_next.cbe_out = ~hst_be_i;
        s_next.ad_out = hst_wdata_i;
        s_next.ad_oe = hst_cmd_i[CMD_WR_BIT];
        s_next.m_cnt = '0;
      end
      M_DATA: begin
        s_next.m_cnt = s_reg.m_cnt + 1'b1;
        if ((!bus.trdy_n && !bus.devsel_n) ||
            (bus.devsel_n && s_reg.m_cnt == ABORT_CYC)) begin
          s_next.done = !bus.devsel_n;
          s_next.abort = bus.devsel_n;
          s_next.rdata = bus.ad;
          s_next.mst = M_TURN;
          s_next.irdy_a = 1'b0;
          s_next.ad_oe = 1'b0;
        end
      end
      M_TURN: begin
        s_next.m_oe = 1'b0;
        s_next.mst = M_IDLE;
      end
      default: begin
        s_next.mst = M_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Bus reset held low through local reset, released at the first edge that sees it ended
  assign bus.rst_n = s_reg.rst_done;
  assign bus.gnt_n = !s_reg.gnt_a;
  assign bus.idsel = s_reg.idsel_a;
  assign bus.h_frame_n = !s_reg.frame_a;
  assign bus.h_irdy_n = !s_reg.irdy_a;
  assign bus.h_frame_oe = s_reg.m_oe && s_reg.rst_done;
  assign bus.h_irdy_oe = s_reg.m_oe && s_reg.rst_done;
  assign bus.h_cbe_oe = s_reg.m_oe && s_reg.rst_done;
  assign bus.h_cbe_n = s_reg.cbe_out;
  assign bus.h_trdy_n = !s_reg.trdy_a;
  assign bus.h_devsel_n = !s_reg.devsel_a;
  assign bus.h_tgt_oe = s_reg.t_oe && s_reg.rst_done;
  assign bus.h_ad = s_reg.ad_out;
  assign bus.h_ad_oe = s_reg.ad_oe && s_reg.rst_done;
  assign hst_busy_o = (s_reg.mst != M_IDLE);
  assign hst_done_o = s_reg.done;
  assign hst_abort_o = s_reg.abort;
  assign hst_rdata_o = s_reg.rdata;

endmodule : pbi_hst_end
`default_nettype wire

// ### dv/pbi_link_monitor.sv
// Checker for the PCI wires joining the device end and the host end.
// Assumes it sits beside the bus interface and sees resolved levels.
`timescale 1ns/10ps
`default_nettype none
module pbi_link_monitor
  import pbi_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic frame_n,
  input wire logic irdy_n,
  input wire logic trdy_n,
  input wire logic devsel_n,
  input wire logic [AD_W-1:0] ad,
  input wire logic [BE_W-1:0] cbe_n,
  input wire logic idsel,
  input wire logic gnt_n,
  input wire logic rst_n,
  input wire logic d_frame_oe,
  input wire logic d_irdy_oe,
  input wire logic d_tgt_oe,
  input wire logic d_ad_oe,
  input wire logic d_cbe_oe,
  input wire logic h_tgt_oe,
  input wire logic h_ad_oe,
  input wire logic h_frame_oe
);
  logic frame_q;
  logic [3:0] cmd_q;
  logic addr_ph;

  // Address phase is the first cycle frame is seen low
  assign addr_ph = !frame_n && frame_q;

  // Command kept so data phases know read from write
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      frame_q <= 1'b1;
      cmd_q <= 4'h0;
    end else begin
      frame_q <= frame_n;
      if (addr_ph) begin
        cmd_q <= cbe_n;
      end
    end
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);

  sequence cfg_addr_s;
    addr_ph && h_frame_oe && idsel && ad[1:0] == ADDR_TYPE0 &&
      (cbe_n == CMD_CFG_RD || cbe_n == CMD_CFG_WR);
  endsequence
  sequence dev_answer_s;
    !devsel_n && d_tgt_oe ##1 !devsel_n && !trdy_n;
  endsequence

  a_cfg_claim: assert property (cfg_addr_s |=> dev_answer_s)
    else $error("config cycle not claimed in time");
  a_no_claim: assert property (addr_ph && !idsel |=> !d_tgt_oe [*3])
    else $error("device claimed without select");
  a_idsel_cfg: assert property (idsel |-> addr_ph && cbe_n[3:1] == 3'h5)
    else $error("select outside config address phase");
  a_grant_first: assert property ($rose(d_frame_oe) |->
    $past(gnt_n) == 1'b0 && $past(frame_n) && $past(irdy_n))
    else $error("device drove frame without grant on idle bus");
  a_addr_single: assert property (addr_ph |=> frame_n && !irdy_n)
    else $error("address phase not one cycle");
  a_read_data: assert property (!trdy_n && !cmd_q[CMD_WR_BIT] |->
    d_ad_oe == d_tgt_oe && h_ad_oe == h_tgt_oe)
    else $error("read data not driven by target");
  a_be_hold: assert property (!irdy_n && trdy_n && !devsel_n |=>
    $stable(cbe_n) && !irdy_n)
    else $error("byte enables moved in data phase");
  a_one_data: assert property (!irdy_n && !trdy_n |=> irdy_n && frame_n)
    else $error("transfer did not end after data phase");
  // Kept live through local reset: only the bus reset gating holds here
  a_rst_float: assert property (disable iff (1'b0) !rst_n |->
    !(d_frame_oe || d_irdy_oe || d_tgt_oe || d_ad_oe || d_cbe_oe))
    else $error("device drives during bus reset");
endmodule : pbi_link_monitor
`default_nettype wire

// ### dv/pbi_bus_pin_interface_test.sv
// Bench joining device and host ends through the bus interface.
// Assumes one clock at 200 MHz and requests only from an idle master.
`timescale 1ns/10ps
`default_nettype none
module pci_bus_pin_interface_test;
  import pbi_pkg::*;
  localparam logic [31:0] ID_VAL = 32'h1357_9bdf; // Arbitrary value
  logic sys_clk, rstn, rstn_dev, mst_req, hst_req, mst_busy, hst_busy, ab;
  logic mst_done, mst_abort, hst_done, hst_abort;
  logic [3:0] mst_cmd, hst_cmd, mst_be, hst_be;
  logic [31:0] mst_addr, mst_wdata, hst_addr, hst_wdata, rd, exp, wd;
  logic [31:0] mst_rdata, hst_rdata, cfg_ctrl;
  logic [3:0] be_tab [4] = '{4'h1, 4'h8, 4'h6, 4'h9};
  int fails = 0;
  int compares = 0;

  pbi_bus_if pbi_bus_if_i();
  pbi_dev_end #(.DEV_ID(ID_VAL)) pbi_dev_end_i (.sys_clk_i(sys_clk),
    .rstn_i(rstn_dev), .bus(pbi_bus_if_i.dev_mp), .mst_req_i(mst_req),
    .mst_cmd_i(mst_cmd), .mst_addr_i(mst_addr), .mst_be_i(mst_be),
    .mst_wdata_i(mst_wdata), .mst_busy_o(mst_busy), .mst_done_o(mst_done),
    .mst_abort_o(mst_abort), .mst_rdata_o(mst_rdata),
    .cfg_ctrl_o(cfg_ctrl));
  pbi_hst_end pbi_hst_end_i (.sys_clk_i(sys_clk), .rstn_i(rstn),
    .bus(pbi_bus_if_i.hst_mp), .hst_req_i(hst_req), .hst_cmd_i(hst_cmd),
    .hst_addr_i(hst_addr), .hst_be_i(hst_be), .hst_wdata_i(hst_wdata),
    .hst_busy_o(hst_busy), .hst_done_o(hst_done),
    .hst_abort_o(hst_abort), .hst_rdata_o(hst_rdata));
  pbi_link_monitor pbi_link_monitor_i (.sys_clk_i(sys_clk), .rstn_i(rstn),
    .frame_n(pbi_bus_if_i.frame_n), .irdy_n(pbi_bus_if_i.irdy_n),
    .trdy_n(pbi_bus_if_i.trdy_n), .devsel_n(pbi_bus_if_i.devsel_n),
    .ad(pbi_bus_if_i.ad), .cbe_n(pbi_bus_if_i.cbe_n),
    .idsel(pbi_bus_if_i.idsel), .gnt_n(pbi_bus_if_i.gnt_n),
    .rst_n(pbi_bus_if_i.rst_n), .d_frame_oe(pbi_bus_if_i.d_frame_oe),
    .d_irdy_oe(pbi_bus_if_i.d_irdy_oe), .d_tgt_oe(pbi_bus_if_i.d_tgt_oe),
    .d_ad_oe(pbi_bus_if_i.d_ad_oe), .d_cbe_oe(pbi_bus_if_i.d_cbe_oe),
    .h_tgt_oe(pbi_bus_if_i.h_tgt_oe), .h_ad_oe(pbi_bus_if_i.h_ad_oe),
    .h_frame_oe(pbi_bus_if_i.h_frame_oe));

  // Clock at 5 ns period
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  // One transfer from the device master (dv) or host master
  task automatic acc(input bit dv, input logic [3:0] cmd,
    input logic [31:0] addr, input logic [3:0] be, input logic [31:0] wd);
    int n;
    n = 0;
    if (dv) begin
      {mst_cmd, mst_addr, mst_be, mst_wdata} = {cmd, addr, be, wd};
      mst_req = 1'b1;
    end else begin
      {hst_cmd, hst_addr, hst_be, hst_wdata} = {cmd, addr, be, wd};
      hst_req = 1'b1;
    end
    // Host inputs must hold until done; device request is one cycle
    do begin
      @(posedge sys_clk);
      #1;
      mst_req = 1'b0;
      n++;
      if (n == 1) begin
        check(32'(dv ? mst_busy : hst_busy), 32'h1);
      end
    end while (!(dv ? (mst_done | mst_abort) : (hst_done | hst_abort)) &&
      n < 100);
    if (n >= 100) begin
      fails++;
      $display("Error at %0t: no completion", $time);
    end
    rd = dv ? mst_rdata : hst_rdata;
    ab = dv ? mst_abort : hst_abort;
    hst_req = 1'b0;
    @(posedge sys_clk);
    #1;
    check(32'(dv ? mst_busy : hst_busy), 32'h0);
  endtask : acc

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #(5 * 5000);
    fails++;
    final_report();
  end

  // Main sequence
  initial begin
    {rstn, rstn_dev, mst_req, hst_req, mst_cmd, hst_cmd, mst_be, hst_be} = '0;
    {mst_addr, mst_wdata, hst_addr, hst_wdata} = '0;
    repeat (20) @(posedge sys_clk);
    #1;
    rstn = 1'b1;
    rstn_dev = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    acc(0, CMD_CFG_WR, 32'h4, 4'hf, 32'ha5c3_0f96);
    check(cfg_ctrl, 32'ha5c3_0f96);
    acc(0, CMD_CFG_WR, 32'h4, 4'h2, 32'h1111_7e22);
    check(cfg_ctrl, 32'ha5c3_7e96);
    acc(0, CMD_CFG_RD, 32'h4, 4'hf, 32'h0);
    check(rd, 32'ha5c3_7e96);
    acc(0, CMD_CFG_WR, 32'h0, 4'hf, 32'h5a5a_5a5a);
    acc(0, CMD_CFG_RD, 32'h0, 4'hf, 32'h0);
    check(rd, ID_VAL);
    acc(0, CMD_IO_RD, 32'h4, 4'hf, 32'h0);
    check(32'(ab), 32'h1);
    acc(0, CMD_CFG_RD, 32'h5, 4'hf, 32'h0);
    check(32'(ab), 32'h1);
    $display("test config done");
    // Device master: lane-selective writes read back from host memory
    exp = 32'h0123_4567;
    acc(1, CMD_MEM_WR, 32'h1c, 4'hf, exp);
    for (int i = 0; i < 4; i++) begin
      wd = 32'hf0e1_d2c3 + 32'(i) * 32'h0101_0101;
      acc(1, CMD_MEM_WR, 32'h1c, be_tab[i], wd);
      for (int k = 0; k < 4; k++) begin
        if (be_tab[i][k]) begin
          exp[8*k +: 8] = wd[8*k +: 8];
        end
      end
      acc(1, CMD_MEM_RD, 32'h1c, 4'hf, 32'h0);
      check(rd, exp);
    end
    acc(1, CMD_IO_WR, 32'h1c, 4'hf, 32'h0);
    check(32'(ab), 32'h1);
    $display("test master done");
    // Host-only reset mid-transfer: the bus reset must float the device
    // pins before the device's own state has a chance to clear
    {mst_cmd, mst_addr, mst_be, mst_wdata} = {CMD_MEM_WR, 32'h8, 4'hf, 32'h0};
    mst_req = 1'b1;
    @(posedge sys_clk);
    #1 mst_req = 1'b0;
    for (int n = 0; n < 20 && !pbi_bus_if_i.d_frame_oe; n++) begin
      @(posedge sys_clk);
      #1;
    end
    rstn = 1'b0;
    @(posedge sys_clk);
    #1;
    check(32'({pbi_bus_if_i.d_frame_oe, pbi_bus_if_i.d_irdy_oe,
      pbi_bus_if_i.d_ad_oe, pbi_bus_if_i.d_cbe_oe,
      pbi_bus_if_i.d_tgt_oe}), 32'h0);
    repeat (2) @(posedge sys_clk);
    #1 rstn = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    check(cfg_ctrl, 32'h0);
    // Host memory clears with the host, so write it again first
    acc(1, CMD_MEM_WR, 32'h1c, 4'hf, exp);
    acc(1, CMD_MEM_RD, 32'h1c, 4'hf, 32'h0);
    check(rd, exp);
    $display("test reset done");
    final_report();
  end
endmodule : pci_bus_pin_interface_test
`default_nettype wire
